/* common/dma_ctrl_params.svh */
// register offsets, field positions, reset values and select codes of the transfer controller
`ifndef DMA_CTRL_PARAMS_SVH
`define DMA_CTRL_PARAMS_SVH
// ============================================================
// channel register offsets (word index inside a channel slot)
`define REG_MAR 2'h0
`define REG_IO_ADDRESS_LOW_BYTE 2'h1
`define REG_TRANSFER_COUNTER 2'h2
`define REG_CTRL 2'h3
// ============================================================
// control register field positions
`define CTRL_EN 7
`define CTRL_SIZE 6
`define CTRL_DIR 5
`define CTRL_STEP 4
`define CTRL_IRQ 3
`define CTRL_MODE_LO 8
`define CTRL_FULL 10
`define CTRL_BLOCK 11
`define CTRL_AREA_SRC 12
// ============================================================
// reset values and masks
`define CTRL_RST 16'h0000
`define CTRL_WMASK 16'h1FFF
`define MAR_RST 24'h000000
`define IO_ADDRESS_LOW_BYTE_RST 8'h00
`define TRANSFER_COUNTER_RST 16'h0000
`define IO_HIGH 16'hFFFF
// ============================================================
// activation select codes
`define SEL_AUTO_BURST 3'h0
`define SEL_AUTO_CYCLE 3'h2
`define SEL_SER_TX 3'h4
`define SEL_SER_RX 3'h5
`define SEL_EXT_FALL 3'h6
`define SEL_EXT_LOW 3'h7
`endif

/* common/dma_ctrl_pkg.sv */
// types shared by the transfer controller
package dma_ctrl_pkg;
  // ============================================================
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_UPDATE = 3'b100
  } eng_state_t;
  // short-address channel modes; code 11 behaves as i/o mode
  typedef enum logic [1:0] {
    SM_IO = 2'b00,
    SM_IDLE = 2'b01,
    SM_REPEAT = 2'b10,
    SM_SPARE = 2'b11
  } short_mode_t;
endpackage : dma_ctrl_pkg

/* rtl/dma_channel_mode_control.sv */
// eight-channel transfer controller: short-address and paired full-address modes
// Operation
// - paired normal select: burst, steal, edge, level
// - block select: timer 0-3 or pin edge
// - shared trigger serviced in fixed priority order
// - eight short channels; pin only on B
// - full modes pair A and B, 24-bit addresses
// - repeat restores address and count, no interrupt
// - idle mode holds both addresses fixed
// - auto-request runs once enabled until count ends
// - cycle-steal releases bus after each unit
// - burst keeps bus unless higher master asks
// - block moves whole block, restores one address
// - receive-full reads i/o, else writes i/o
// - i/o mode steps memory address per unit
// - i/o address high bits all ones, fixed
// - counter decrements; zero clears enable, stops
// - end interrupt only when its enable set
// - counter zero means 65,536 transfers
// - i/o mode accepts timer, serial, pin triggers
// - each short channel picks its mode alone
// - paired run needs master and channel enable
// - size bit picks byte or word step
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`include "dma_ctrl_params.svh"
module dma_channel_mode_control (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register bus
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // activation sources
  input wire logic [3:0] i_timer_evt,
  input wire logic i_ser_tx_empty,
  input wire logic i_ser_rx_full,
  input wire logic [3:0] i_ext_req_n,
  input wire logic i_nmi,
  // system bus
  output logic o_bus_req,
  input wire logic i_bus_grant,
  input wire logic i_bus_higher_req,
  output logic [23:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic o_mem_word,
  output logic [15:0] o_mem_wdata,
  input wire logic [15:0] i_mem_rdata,
  input wire logic i_mem_ready,
  // end-of-transfer requests
  output logic [7:0] o_end_irq
);
  // ============================================================
  // storage
  logic [23:0] memory_address_pointer [8];
  logic [7:0] io_address_low_byte [8];
  logic [15:0] transfer_counter [8];
  logic [15:0] ctrl [8];
  logic [7:0] end_flag;
  logic [7:0] pend;
  logic [7:0] req;
  logic [7:0] usable;
  logic [2:0] cur;
  logic [2:0] pick;
  dma_ctrl_pkg::eng_state_t state;
  logic [3:0] ext_s1, ext_s2, ext_s3;
  logic [3:0] ext_fall;
  logic ack;
  logic reg_wr;
  logic [2:0] wch;
  logic [1:0] wreg;
  logic [31:0] wmerged;
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                            input logic dec, input logic word);
    logic [23:0] d;
    d = word ? 24'h000002 : 24'h000001;
    if (!en) step_addr = a;
    else if (dec) step_addr = a - d;
    else step_addr = a + d;
  endfunction : step_addr
  function automatic logic [23:0] restore_addr(input logic [23:0] a, input logic en,
                                               input logic dec, input logic word,
                                               input logic [7:0] n);
    logic [23:0] d;
    d = {16'h0000, n} << word;
    if (!en) restore_addr = a;
    else if (dec) restore_addr = a + d;
    else restore_addr = a - d;
  endfunction : restore_addr
  // ============================================================
  // external request pins; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_s1 <= 4'hF;
      ext_s2 <= 4'hF;
      ext_s3 <= 4'hF;
    end else if (i_ce) begin
      ext_s1 <= i_ext_req_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  assign ext_fall = ext_s3 & ~ext_s2;
  // ============================================================
  // engine next values
  logic [2:0] ia, ib;
  logic full, blk, word, rx_sel, term, cont, upd;
  dma_ctrl_pkg::short_mode_t smode;
  logic [23:0] src, dst, io_addr;
  logic [23:0] next_mar_s, next_mar_a, next_mar_b;
  logic [15:0] next_cnt_s, next_cnt_a, next_cnt_b;
  logic [7:0] blk_left, rep_left;
  always_comb begin
    ia = {cur[2:1], 1'b0};
    ib = {cur[2:1], 1'b1};
    full = ctrl[ia][`CTRL_FULL];
    blk = ctrl[ia][`CTRL_BLOCK];
    smode = dma_ctrl_pkg::short_mode_t'(ctrl[cur][`CTRL_MODE_LO +: 2]);
    word = full ? ctrl[ia][`CTRL_SIZE] : ctrl[cur][`CTRL_SIZE];
    rx_sel = ctrl[cur][2:0] == `SEL_SER_RX;
    io_addr = {`IO_HIGH, io_address_low_byte[cur]};
    src = full ? memory_address_pointer[ia] : (rx_sel ? io_addr : memory_address_pointer[cur]);
    dst = full ? memory_address_pointer[ib] : (rx_sel ? memory_address_pointer[cur] : io_addr);
    upd = (state == dma_ctrl_pkg::ST_UPDATE);
    next_mar_s = memory_address_pointer[cur];
    next_cnt_s = transfer_counter[cur] - 16'h0001;
    rep_left = transfer_counter[cur][15:8] - 8'h01;
    next_mar_a = step_addr(memory_address_pointer[ia], ctrl[ia][`CTRL_STEP], ctrl[ia][`CTRL_DIR], word);
    next_mar_b = step_addr(memory_address_pointer[ib], ctrl[ib][`CTRL_STEP], ctrl[ib][`CTRL_DIR], word);
    next_cnt_a = transfer_counter[ia] - 16'h0001;
    next_cnt_b = transfer_counter[ib];
    blk_left = transfer_counter[ia][15:8] - 8'h01;
    term = 1'b0;
    cont = 1'b0;
    if (full && blk) begin
      next_cnt_a = {blk_left, transfer_counter[ia][7:0]};
      if (blk_left == 8'h00) begin
        next_cnt_a = {transfer_counter[ia][7:0], transfer_counter[ia][7:0]};
        next_cnt_b = transfer_counter[ib] - 16'h0001;
        term = next_cnt_b == 16'h0000;
        if (ctrl[ib][`CTRL_AREA_SRC])
          next_mar_a = restore_addr(next_mar_a, ctrl[ia][`CTRL_STEP],
                                    ctrl[ia][`CTRL_DIR], word, transfer_counter[ia][7:0]);
        else
          next_mar_b = restore_addr(next_mar_b, ctrl[ib][`CTRL_STEP],
                                    ctrl[ib][`CTRL_DIR], word, transfer_counter[ia][7:0]);
      end else begin
        cont = 1'b1;
      end
    end else if (full) begin
      term = next_cnt_a == 16'h0000;
      cont = ctrl[ib][2:0] == `SEL_AUTO_BURST && !term && !i_bus_higher_req
             && !i_nmi && ctrl[ib][`CTRL_EN];
    end else begin
      unique case (smode)
        dma_ctrl_pkg::SM_IDLE: begin
          term = next_cnt_s == 16'h0000;
        end
        dma_ctrl_pkg::SM_REPEAT: begin
          next_mar_s = step_addr(memory_address_pointer[cur], ctrl[cur][`CTRL_STEP], ctrl[cur][`CTRL_DIR], word);
          next_cnt_s = {rep_left, transfer_counter[cur][7:0]};
          if (rep_left == 8'h00) begin
            next_cnt_s = {transfer_counter[cur][7:0], transfer_counter[cur][7:0]};
            next_mar_s = restore_addr(next_mar_s, ctrl[cur][`CTRL_STEP],
                                      ctrl[cur][`CTRL_DIR], word, transfer_counter[cur][7:0]);
          end
        end
        dma_ctrl_pkg::SM_IO, dma_ctrl_pkg::SM_SPARE: begin
          next_mar_s = step_addr(memory_address_pointer[cur], ctrl[cur][`CTRL_STEP],
                                 ctrl[cur][`CTRL_DIR], word);
          term = next_cnt_s == 16'h0000;
        end
      endcase
    end
  end
  logic [2:0] term_ch;
  assign term_ch = full ? ia : cur;
  // ============================================================
  // per-channel activation decode and pending requests
  for (genvar i = 0; i < 8; i++) begin : g_ch
    localparam int PA = (i / 2) * 2;
    localparam int P = i / 2;
    logic full_a, blk_a, en, lvl, evt, clr;
    logic [2:0] sel;
    assign full_a = ctrl[PA][`CTRL_FULL];
    assign blk_a = ctrl[PA][`CTRL_BLOCK];
    assign sel = full_a ? ctrl[PA + 1][2:0] : ctrl[i][2:0];
    assign en = full_a ? (ctrl[PA][`CTRL_EN] & ctrl[PA + 1][`CTRL_EN])
                       : ctrl[i][`CTRL_EN];
    always_comb begin
      usable[i] = 1'b0;
      lvl = 1'b0;
      evt = 1'b0;
      if (full_a) begin
        if ((i % 2) == 0 && blk_a) begin
          if (!sel[2]) begin
            usable[i] = 1'b1;
            evt = i_timer_evt[sel[1:0]];
          end else if (sel == `SEL_EXT_FALL) begin
            usable[i] = 1'b1;
            evt = ext_fall[P];
          end
        end else if ((i % 2) == 0) begin
          if (sel == `SEL_AUTO_BURST || sel == `SEL_AUTO_CYCLE) begin
            usable[i] = 1'b1;
            lvl = 1'b1;
          end else if (sel == `SEL_EXT_FALL) begin
            usable[i] = 1'b1;
            evt = ext_fall[P];
          end else if (sel == `SEL_EXT_LOW) begin
            usable[i] = 1'b1;
            lvl = ~ext_s2[P];
          end
        end
      end else if (!sel[2]) begin
        usable[i] = 1'b1;
        evt = i_timer_evt[sel[1:0]];
      end else if (sel == `SEL_SER_TX || sel == `SEL_SER_RX) begin
        usable[i] = 1'b1;
        evt = sel[0] ? i_ser_rx_full : i_ser_tx_empty;
      end else if (sel == `SEL_EXT_FALL && (i % 2) == 1) begin
        usable[i] = 1'b1;
        evt = ext_fall[P];
      end
    end
    assign clr = upd && !cont && cur == 3'(i);
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        pend[i] <= 1'b0;
      end else if (i_ce) begin
        if (!en || !usable[i]) pend[i] <= 1'b0;
        else pend[i] <= (pend[i] & ~clr) | evt;
      end
    end
    assign req[i] = en & usable[i] & (lvl | pend[i]);
    assign o_end_irq[i] = end_flag[i] & ctrl[i][`CTRL_IRQ];
    a_unusable_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !usable[i] |-> !req[i]) else $error("request from unusable select");
  end
  // lowest index wins; one trigger feeding several channels drains them in turn
  always_comb begin
    pick = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (req[k]) pick = 3'(k);
    end
  end
  // ============================================================
  // engine
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= dma_ctrl_pkg::ST_IDLE;
      cur <= 3'h0;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_mem_word <= 1'b0;
    end else if (i_ce) begin
      unique case (state)
        dma_ctrl_pkg::ST_IDLE: begin
          if (|req) begin
            cur <= pick;
            state <= dma_ctrl_pkg::ST_ARB;
          end
        end
        dma_ctrl_pkg::ST_ARB: begin
          if (i_bus_grant) begin
            o_mem_addr <= src;
            o_mem_word <= word;
            state <= dma_ctrl_pkg::ST_READ;
          end
        end
        dma_ctrl_pkg::ST_READ: begin
          if (i_mem_ready) begin
            o_mem_wdata <= i_mem_rdata;
            o_mem_addr <= dst;
            state <= dma_ctrl_pkg::ST_WRITE;
          end
        end
        dma_ctrl_pkg::ST_WRITE: begin
          if (i_mem_ready) state <= dma_ctrl_pkg::ST_UPDATE;
        end
        dma_ctrl_pkg::ST_UPDATE: begin
          // dropping to idle releases the bus for a cycle
          state <= cont ? dma_ctrl_pkg::ST_ARB : dma_ctrl_pkg::ST_IDLE;
        end
        default: state <= dma_ctrl_pkg::ST_IDLE;
      endcase
    end
  end
  assign o_bus_req = state != dma_ctrl_pkg::ST_IDLE;
  assign o_mem_rd = state == dma_ctrl_pkg::ST_READ;
  assign o_mem_wr = state == dma_ctrl_pkg::ST_WRITE;
  // ============================================================
  // register bus: one wait cycle per access
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ack <= 1'b0;
    else if (i_ce) ack <= (i_avs_read | i_avs_write) & ~ack;
  end
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(ack & i_ce);
  assign reg_wr = i_avs_write & ack;
  assign wch = i_avs_address[4:2];
  assign wreg = i_avs_address[1:0];
  always_comb begin
    wmerged = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      wmerged[b * 8 +: 8] = i_avs_byteenable[b] ? i_avs_writedata[b * 8 +: 8] :
        (wreg == `REG_MAR) ? 8'({8'h00, memory_address_pointer[wch]} >> (b * 8)) :
        (wreg == `REG_IO_ADDRESS_LOW_BYTE) ? 8'({24'h000000, io_address_low_byte[wch]} >> (b * 8)) :
        (wreg == `REG_TRANSFER_COUNTER) ? 8'({16'h0000, transfer_counter[wch]} >> (b * 8)) :
        8'({16'h0000, ctrl[wch]} >> (b * 8));
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce && i_avs_read && !ack) begin
      unique case (wreg)
        `REG_MAR: o_avs_readdata <= {8'h00, memory_address_pointer[wch]};
        `REG_IO_ADDRESS_LOW_BYTE: o_avs_readdata <= {24'h000000, io_address_low_byte[wch]};
        `REG_TRANSFER_COUNTER: o_avs_readdata <= {16'h0000, transfer_counter[wch]};
        `REG_CTRL: o_avs_readdata <= {16'h0000, ctrl[wch]};
      endcase
    end
  end
  // ============================================================
  // address and counter registers; a bus write in the same cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 8; k++) begin
        memory_address_pointer[k] <= `MAR_RST;
        io_address_low_byte[k] <= `IO_ADDRESS_LOW_BYTE_RST;
        transfer_counter[k] <= `TRANSFER_COUNTER_RST;
      end
    end else if (i_ce) begin
      if (upd && full) begin
        memory_address_pointer[ia] <= next_mar_a;
        memory_address_pointer[ib] <= next_mar_b;
        transfer_counter[ia] <= next_cnt_a;
        transfer_counter[ib] <= next_cnt_b;
      end else if (upd) begin
        memory_address_pointer[cur] <= next_mar_s;
        transfer_counter[cur] <= next_cnt_s;
      end
      if (reg_wr && wreg == `REG_MAR) memory_address_pointer[wch] <= wmerged[23:0];
      if (reg_wr && wreg == `REG_IO_ADDRESS_LOW_BYTE) io_address_low_byte[wch] <= wmerged[7:0];
      if (reg_wr && wreg == `REG_TRANSFER_COUNTER) transfer_counter[wch] <= wmerged[15:0];
    end
  end
  // ============================================================
  // control and end flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 8; k++) ctrl[k] <= `CTRL_RST;
    end else if (i_ce) begin
      if (upd && term) ctrl[term_ch][`CTRL_EN] <= 1'b0;
      for (int k = 1; k < 8; k += 2) begin
        if (i_nmi && ctrl[k - 1][`CTRL_FULL]) ctrl[k][`CTRL_EN] <= 1'b0;
      end
      if (reg_wr && wreg == `REG_CTRL) ctrl[wch] <= wmerged[15:0] & `CTRL_WMASK;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      end_flag <= 8'h00;
    end else if (i_ce) begin
      for (int k = 0; k < 8; k++) begin
        if (reg_wr && wreg == `REG_CTRL && wch == 3'(k)) end_flag[k] <= 1'b0;
        if (upd && term && term_ch == 3'(k)) end_flag[k] <= 1'b1;
      end
    end
  end
  // ============================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic rep_upd, idle_upd, io_upd, steal_upd;
  assign rep_upd = upd && !full && smode == dma_ctrl_pkg::SM_REPEAT && i_ce;
  assign idle_upd = upd && !full && smode == dma_ctrl_pkg::SM_IDLE && i_ce && !reg_wr;
  assign io_upd = upd && !full && smode == dma_ctrl_pkg::SM_IO && i_ce && !reg_wr;
  assign steal_upd = upd && full && !blk && ctrl[ib][2:0] == `SEL_AUTO_CYCLE && i_ce;
  a_io_high_ones: assert property (o_mem_rd && !full && rx_sel
    |-> o_mem_addr[23:8] == `IO_HIGH) else $error("i/o address high not ones");
  a_rx_dir_write: assert property (o_mem_wr && !full && rx_sel
    |-> o_mem_addr == memory_address_pointer[cur]) else $error("receive-full wrong direction");
  a_repeat_no_irq: assert property (rep_upd |=> end_flag == $past(end_flag))
    else $error("repeat mode raised end flag");
  a_idle_addr_fixed: assert property (idle_upd |=> memory_address_pointer[$past(cur)] == $past(memory_address_pointer[cur]))
    else $error("idle mode moved address");
  a_io_count_dec: assert property (io_upd
    |=> transfer_counter[$past(cur)] == $past(transfer_counter[cur]) - 16'h0001)
    else $error("counter not decremented");
  a_term_clears_en: assert property (upd && term && i_ce && !reg_wr
    |=> !ctrl[$past(term_ch)][`CTRL_EN] && end_flag[$past(term_ch)])
    else $error("end did not clear enable");
  a_steal_release: assert property (steal_upd |=> !o_bus_req)
    else $error("cycle steal kept bus");
  a_prio_pick: assert property (state == dma_ctrl_pkg::ST_IDLE && |req && i_ce
    |=> cur == $past(pick) && !$past(req[0] && pick != 3'h0))
    else $error("priority order broken");
  a_read_write: assert property (o_mem_rd && i_mem_ready && i_ce |=> o_mem_wr [*1])
    else $error("read not followed by write");
  a_bus_wait: assert property (i_avs_read && !ack && i_ce |=> !o_avs_waitrequest || !i_avs_read)
    else $error("bus answer late");
  c_burst_cont: cover property (upd && cont && full && !blk);
  c_block_end: cover property (upd && full && blk && blk_left == 8'h00);
  c_repeat_wrap: cover property (rep_upd && rep_left == 8'h00);
  c_term_irq: cover property (|o_end_irq);
endmodule : dma_channel_mode_control

/* test/mem_model.sv */
// memory and bus grant model on the controller's system bus side
module mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // requests from the controller, wait count from the bench
  input wire logic i_bus_req,
  input wire logic [23:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [1:0] i_wait,
  // answers
  output logic o_grant,
  output logic [15:0] o_rdata,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  logic [15:0] junk;
  // ============================================================
  // grant one cycle after request, wait states per i_wait
  always_ff @(posedge i_clk) begin
    o_grant <= i_rst_n & i_bus_req;
    junk <= ~junk ^ 16'h0001;
    if (!i_rst_n || !(i_rd || i_wr) || o_ready) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  assign o_ready = (i_rd || i_wr) && (cnt == i_wait);
  // data is only meaningful with ready; otherwise it keeps changing
  assign o_rdata = o_ready ? (i_addr[15:0] ^ 16'hC3A5) : junk;
endmodule : mem_model

/* test/test_dma_channel_mode_control.sv */
// self-checking bench of the transfer controller
`include "dma_ctrl_params.svh"
module test_dma_channel_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] a = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] tev = 4'h0;
  logic tx = 1'b0;
  logic rx = 1'b0;
  logic [3:0] ext_n = 4'hF;
  logic nmi = 1'b0;
  logic [1:0] slow = 2'h0;
  logic bus_req, grant, mrd, mwr, mword, mready, bus_req_d;
  logic [23:0] maddr;
  logic [15:0] mwdata, mrdata;
  logic [7:0] irq;
  logic [31:0] q;
  logic [23:0] wq[$];
  logic [23:0] rq[$];
  logic [15:0] dq[$];
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int falls = 0;
  int f0;
  // ============================================================
  // design and partner
  dma_channel_mode_control uut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_avs_address(a), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_timer_evt(tev), .i_ser_tx_empty(tx), .i_ser_rx_full(rx), .i_ext_req_n(ext_n),
    .i_nmi(nmi), .o_bus_req(bus_req), .i_bus_grant(grant), .i_bus_higher_req(1'b0),
    .o_mem_addr(maddr), .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_word(mword),
    .o_mem_wdata(mwdata), .i_mem_rdata(mrdata), .i_mem_ready(mready), .o_end_irq(irq));
  mem_model partner (.i_clk(clk), .i_rst_n(rst_n), .i_bus_req(bus_req), .i_addr(maddr),
    .i_rd(mrd), .i_wr(mwr), .i_wait(slow), .o_grant(grant), .o_rdata(mrdata),
    .o_ready(mready));
  always #25 clk = ~clk;
  // ============================================================
  // monitor and timeout
  always @(posedge clk) begin
    cycles++;
    bus_req_d <= bus_req;
    if (bus_req_d === 1'b1 && bus_req === 1'b0) falls++;
    if (mrd === 1'b1 && mready === 1'b1) rq.push_back(maddr);
    if (mwr === 1'b1 && mready === 1'b1) begin
      wq.push_back(maddr);
      dq.push_back(mwdata);
    end
    if (cycles > 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // ============================================================
  // tasks
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low before the sampling edge
  task automatic acc(input logic w, input logic [2:0] ch, input logic [1:0] r,
                     input logic [31:0] d);
    a <= {ch, r};
    wr <= w;
    rd <= ~w;
    wd <= d;
    do @(negedge clk); while (wreq !== 1'b0);
    @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic w(input logic [2:0] ch, input logic [1:0] r, input logic [31:0] d);
    acc(1'b1, ch, r, d);
  endtask : w
  task automatic rc(input logic [2:0] ch, input logic [1:0] r, input logic [31:0] e);
    acc(1'b0, ch, r, 32'h00000000);
    chk(q, e);
  endtask : rc
  task automatic fire(input logic [3:0] t, input logic x, input logic y);
    tev <= t;
    tx <= x;
    rx <= y;
    @(posedge clk);
    tev <= 4'h0;
    tx <= 1'b0;
    rx <= 1'b0;
    @(posedge clk);
  endtask : fire
  // wait for n bus writes in all and the engine back at rest
  task automatic done(input int n);
    while (wq.size() < n || bus_req !== 1'b0) @(negedge clk);
    @(posedge clk);
  endtask : done
  // ============================================================
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 4; r++) rc(3'h6, r[1:0], 32'h00000000);
    // i/o mode on timer 0, memory to i/o
    w(3'h0, `REG_MAR, 32'h00001000);
    w(3'h0, `REG_IO_ADDRESS_LOW_BYTE, 32'h00000040);
    w(3'h0, `REG_TRANSFER_COUNTER, 32'h00000002);
    w(3'h0, `REG_CTRL, 32'h00000098);
    fire(4'h1, 1'b0, 1'b0);
    done(1);
    chk(32'(rq[0]), 32'h00001000);
    chk(32'(wq[0]), 32'h00FFFF40);
    rc(3'h0, `REG_MAR, 32'h00001001);
    rc(3'h0, `REG_TRANSFER_COUNTER, 32'h00000001);
    fire(4'h1, 1'b0, 1'b0);
    done(2);
    chk(32'(wq[1]), 32'h00FFFF40);
    rc(3'h0, `REG_CTRL, 32'h00000018);
    chk(32'(irq[0]), 32'h00000001);
    // receive-full word transfer, decrementing, slow partner
    slow <= 2'h2;
    w(3'h1, `REG_MAR, 32'h00002010);
    w(3'h1, `REG_IO_ADDRESS_LOW_BYTE, 32'h00000055);
    w(3'h1, `REG_TRANSFER_COUNTER, 32'h00000001);
    w(3'h1, `REG_CTRL, 32'h000000F5);
    fire(4'h0, 1'b0, 1'b1);
    done(3);
    chk(32'(rq[2]), 32'h00FFFF55);
    chk(32'(wq[2]), 32'h00002010);
    chk(32'(dq[2]), 32'(16'hFF55 ^ 16'hC3A5));
    rc(3'h1, `REG_MAR, 32'h0000200E);
    rc(3'h1, `REG_CTRL, 32'h00000075);
    chk(32'(irq[1]), 32'h00000000);
    slow <= 2'h0;
    // one transmit event for idle channel 2 and repeat channel 3
    w(3'h2, `REG_MAR, 32'h00003000);
    w(3'h2, `REG_IO_ADDRESS_LOW_BYTE, 32'h00000020);
    w(3'h2, `REG_TRANSFER_COUNTER, 32'h00000005);
    w(3'h2, `REG_CTRL, 32'h00000194);
    w(3'h3, `REG_MAR, 32'h00004000);
    w(3'h3, `REG_IO_ADDRESS_LOW_BYTE, 32'h00000030);
    w(3'h3, `REG_TRANSFER_COUNTER, 32'h00000101);
    w(3'h3, `REG_CTRL, 32'h0000029C);
    fire(4'h0, 1'b1, 1'b0);
    done(5);
    chk(32'(wq[3]), 32'h00FFFF20);
    chk(32'(wq[4]), 32'h00FFFF30);
    rc(3'h2, `REG_MAR, 32'h00003000);
    rc(3'h2, `REG_TRANSFER_COUNTER, 32'h00000004);
    rc(3'h3, `REG_MAR, 32'h00004000);
    rc(3'h3, `REG_TRANSFER_COUNTER, 32'h00000101);
    rc(3'h3, `REG_CTRL, 32'h0000029C);
    chk(32'(irq[3]), 32'h00000000);
    // pin fall on A and B of pair 2: only B may move
    w(3'h4, `REG_TRANSFER_COUNTER, 32'h00000001);
    w(3'h4, `REG_CTRL, 32'h00000086);
    w(3'h5, `REG_IO_ADDRESS_LOW_BYTE, 32'h00000061);
    w(3'h5, `REG_TRANSFER_COUNTER, 32'h00000001);
    w(3'h5, `REG_CTRL, 32'h00000086);
    ext_n <= 4'hB;
    done(6);
    ext_n <= 4'hF;
    repeat (30) @(posedge clk);
    chk(32'(wq.size()), 32'd6);
    chk(32'(wq[5]), 32'h00FFFF61);
    rc(3'h4, `REG_CTRL, 32'h00000086);
    // paired normal: burst, cycle-steal, then low level on the pin
    for (int m = 0; m < 3; m++) begin
      f0 = falls;
      w(3'h6, `REG_MAR, 32'h00006000);
      w(3'h7, `REG_MAR, 32'h00007000);
      w(3'h6, `REG_TRANSFER_COUNTER, 32'h00000003);
      w(3'h7, `REG_CTRL, (m == 0) ? 32'h90 : (m == 1) ? 32'h92 : 32'h97);
      if (m == 2) ext_n <= 4'h7;
      w(3'h6, `REG_CTRL, 32'h00000498);
      done(9 + 3 * m);
      ext_n <= 4'hF;
      rc(3'h6, `REG_TRANSFER_COUNTER, 32'h00000000);
      chk(32'(wq[8 + 3 * m]), 32'h00007002);
      chk(32'(rq[8 + 3 * m]), 32'h00006002);
      chk(32'(irq[6]), 32'h00000001);
      if (m == 0) chk(32'(falls - f0), 32'd1);
      if (m == 1) chk(32'(falls - f0), 32'd3);
    end
    // nmi drops the master enable, nothing moves
    w(3'h7, `REG_CTRL, 32'h00000090);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    @(posedge clk);
    rc(3'h7, `REG_CTRL, 32'h00000010);
    w(3'h6, `REG_TRANSFER_COUNTER, 32'h00000001);
    w(3'h6, `REG_CTRL, 32'h00000498);
    repeat (30) @(posedge clk);
    chk(32'(wq.size()), 32'd15);
    // block of two units on timer 2, destination is the block area
    w(3'h0, `REG_MAR, 32'h00008000);
    w(3'h0, `REG_TRANSFER_COUNTER, 32'h00000202);
    w(3'h1, `REG_MAR, 32'h00009000);
    w(3'h1, `REG_TRANSFER_COUNTER, 32'h00000002);
    w(3'h1, `REG_CTRL, 32'h00000092);
    w(3'h0, `REG_CTRL, 32'h00000C90);
    fire(4'h2, 1'b0, 1'b0);
    repeat (30) @(posedge clk);
    chk(32'(wq.size()), 32'd15);
    fire(4'h4, 1'b0, 1'b0);
    done(17);
    chk(32'(wq[16]), 32'h00009001);
    rc(3'h1, `REG_MAR, 32'h00009000);
    rc(3'h1, `REG_TRANSFER_COUNTER, 32'h00000001);
    rc(3'h0, `REG_MAR, 32'h00008002);
    // counter at zero is the largest count
    w(3'h2, `REG_TRANSFER_COUNTER, 32'h00000000);
    fire(4'h0, 1'b1, 1'b0);
    done(19);
    rc(3'h2, `REG_TRANSFER_COUNTER, 32'h0000FFFF);
    rc(3'h2, `REG_CTRL, 32'h00000194);
    stop_test();
  end
endmodule : test_dma_channel_mode_control
